// file: core/nbh_map.svh
`ifndef NBH_MAP_SVH
`define NBH_MAP_SVH

// System clock rate and pin synchroniser depth.
`define NBH_CLK_MHZ 20
`define NBH_SYNC_DEPTH 2

// Least times in ns round up to whole cycles.
`define NBH_NS_UP(ns) (((ns) * `NBH_CLK_MHZ + 999) / 1000)
// Longest times round down to whole cycles.
`define NBH_NS_DN(ns) (((ns) * `NBH_CLK_MHZ) / 1000)
`define NBH_US_DN(us) ((us) * `NBH_CLK_MHZ)

// Pin timing figures.
`define NBH_ADDR_TO_DATA_GAP_NS 100
`define NBH_PROTECT_SETTLE_NS 100
`define NBH_WE_TO_BUSY_NS 100
`define NBH_WE_TO_RE_NS 60
`define NBH_RE_TO_WE_NS 100

// Busy limits.
`define NBH_ARRAY_LOAD_US 25
`define NBH_PROGRAM_BUSY_US 950
`define NBH_CACHE_PROGRAM_BUSY_US 950
`define NBH_PLANE_DUMMY_BUSY_NS 1000
`define NBH_CACHE_READ_BUSY_US 30
`define NBH_RST_READY_US 5
`define NBH_RST_READ_US 5
`define NBH_RST_PROGRAM_US 10
`define NBH_RST_ERASE_US 500

// Derived cycle counts.
`define NBH_ADL_CYC `NBH_NS_UP(`NBH_ADDR_TO_DATA_GAP_NS)
`define NBH_WW_CYC `NBH_NS_UP(`NBH_PROTECT_SETTLE_NS)
`define NBH_WB_CYC (`NBH_NS_UP(`NBH_WE_TO_BUSY_NS) + `NBH_SYNC_DEPTH)
`define NBH_WHR_CYC `NBH_NS_UP(`NBH_WE_TO_RE_NS)
`define NBH_RHW_CYC `NBH_NS_UP(`NBH_RE_TO_WE_NS)
`define NBH_R_CYC `NBH_US_DN(`NBH_ARRAY_LOAD_US)
`define NBH_PROG_CYC `NBH_US_DN(`NBH_PROGRAM_BUSY_US)
`define NBH_CBSY_CYC `NBH_US_DN(`NBH_CACHE_PROGRAM_BUSY_US)
`define NBH_DBSY_CYC `NBH_NS_DN(`NBH_PLANE_DUMMY_BUSY_NS)
`define NBH_DCBSYR_CYC `NBH_US_DN(`NBH_CACHE_READ_BUSY_US)
`define NBH_RST_RDY_CYC `NBH_US_DN(`NBH_RST_READY_US)
`define NBH_RST_RD_CYC `NBH_US_DN(`NBH_RST_READ_US)
`define NBH_RST_PRG_CYC `NBH_US_DN(`NBH_RST_PROGRAM_US)
`define NBH_RST_ERS_CYC `NBH_US_DN(`NBH_RST_ERASE_US)

// Address layout and write limits.
`define NBH_ADDR_CYCLES 3'h5
`define NBH_ROW_LSB 16
`define NBH_PARTIAL_WRITE_LIMIT 3'h4

// Command codes the controller watches.
`define NBH_CMD_PROG_GO 8'h10
`define NBH_CMD_CACHE_PROG 8'h15
`define NBH_CMD_ERASE_GO 8'hd0
`define NBH_CMD_RESET 8'hff
`define NBH_CMD_CACHE_READ 8'h31
`define NBH_CMD_CACHE_LAST 8'h3f

`endif

// file: core/nbh_pkg.sv
package nbh_pkg;

  // Kinds of request on the user command port.
  typedef enum logic [2:0] {
    NBH_OP_CMD = 3'h0,
    NBH_OP_ADDR = 3'h1,
    NBH_OP_WRITE = 3'h2,
    NBH_OP_READ = 3'h3,
    NBH_OP_WAIT = 3'h4,
    NBH_OP_PROTECT = 3'h5
  } nbh_op_t;

  // Busy limit to apply while waiting for ready.
  typedef enum logic [3:0] {
    NBH_BW_ARRAY = 4'h0,
    NBH_BW_PROG = 4'h1,
    NBH_BW_CACHE_PROG = 4'h2,
    NBH_BW_PLANE = 4'h3,
    NBH_BW_CACHE_READ = 4'h4,
    NBH_BW_RST_READY = 4'h5,
    NBH_BW_RST_READ = 4'h6,
    NBH_BW_RST_PROG = 4'h7,
    NBH_BW_RST_ERASE = 4'h8
  } nbh_wait_t;

  // One request: code byte or protect level in value, 40-bit address,
  // byte count for data phases, busy class for waits.
  typedef struct packed {
    nbh_op_t op;
    logic [7:0] value;
    logic [39:0] addr;
    logic [11:0] count;
    nbh_wait_t wclass;
  } nbh_req_t;

  // Pins driven toward the flash.
  typedef struct packed {
    logic cmd_latch;
    logic addr_latch;
    logic chip_sel_n;
    logic write_strobe_n;
    logic output_strobe_n;
    logic protect_n;
  } nbh_pins_t;

endpackage

// file: core/nbh_fifo.sv
module nbh_fifo
  import nbh_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] fill;
  logic push;
  logic pull;

  // Output register refills whenever it is empty or being taken.
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pull = (fill != '0) && (!out_valid || out_ready);

  // Storage array; written only, never reset, to stay a plain RAM.
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wptr] <= in_data;
  end

  // Pointers and fill level.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wptr <= '0;
      rptr <= '0;
      fill <= '0;
    end
    else
    begin
      if (push)
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      if (pull)
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      fill <= fill + (AW+1)'(push) - (AW+1)'(pull);
    end
  end

  // Registered read port; the output word counts as a slot of its own.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pull)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

endmodule

// file: core/nbh_ctrl.sv
`include "nbh_map.svh"
module nbh_ctrl
  import nbh_pkg::*;
#(
  parameter logic [14:0] PROG_LIMIT = 15'(`NBH_PROG_CYC),
  parameter logic [14:0] CACHE_PROG_LIMIT = 15'(`NBH_CBSY_CYC),
  parameter logic [14:0] RST_ERASE_LIMIT = 15'(`NBH_RST_ERS_CYC)
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire nbh_req_t req,
  output logic req_ready,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic op_done,
  output logic op_timeout,
  output logic op_refused,
  output logic cache_read_open,
  output nbh_pins_t pins,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);

  typedef enum logic [3:0] {
    NBH_ST_IDLE = 4'h0,
    NBH_ST_SETUP = 4'h1,
    NBH_ST_WLOW = 4'h2,
    NBH_ST_WHIGH = 4'h3,
    NBH_ST_RLOW = 4'h4,
    NBH_ST_RHOLD = 4'h5,
    NBH_ST_RTAKE = 4'h6,
    NBH_ST_GAP = 4'h7,
    NBH_ST_BUSY = 4'h8
  } nbh_state_t;

  nbh_state_t state;
  nbh_req_t cur;
  logic [11:0] left;
  logic [2:0] aidx;
  logic [14:0] timer;
  logic [14:0] limit;
  logic [23:0] last_row;
  logic [23:0] pend_row;
  logic [2:0] writes;
  logic [7:0] io_s1;
  logic [7:0] io_s2;
  logic rb_s1;
  logic rb_s2;
  logic fifo_valid;
  logic fifo_take;
  logic [7:0] fifo_data;
  logic is_prog;
  logic same_row;

  // Write data is buffered so the source can run ahead of the pins.
  nbh_fifo #(.WIDTH(8), .DEPTH(32)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // Pins from the flash are asynchronous to sys_clk.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end
    else
    begin
      io_s1 <= io_in;
      io_s2 <= io_s1;
      rb_s1 <= ready_busy_n;
      rb_s2 <= rb_s1;
    end
  end

  // A data byte is pulled from the buffer as its setup cycle ends.
  assign fifo_take = (state == NBH_ST_SETUP) && (cur.op == NBH_OP_WRITE)
                     && fifo_valid;

  // Program confirm codes count against the per-page write budget.
  assign is_prog = (req.value == `NBH_CMD_PROG_GO)
                   || (req.value == `NBH_CMD_CACHE_PROG);
  assign same_row = (pend_row == last_row);

  // Busy limit for each class of wait.
  always_comb
  begin
    case (req.wclass)
      NBH_BW_ARRAY: limit = 15'(`NBH_R_CYC);
      NBH_BW_PROG: limit = PROG_LIMIT;
      NBH_BW_CACHE_PROG: limit = CACHE_PROG_LIMIT;
      NBH_BW_PLANE: limit = 15'(`NBH_DBSY_CYC);
      NBH_BW_CACHE_READ: limit = 15'(`NBH_DCBSYR_CYC);
      NBH_BW_RST_READY: limit = 15'(`NBH_RST_RDY_CYC);
      NBH_BW_RST_READ: limit = 15'(`NBH_RST_RD_CYC);
      NBH_BW_RST_PROG: limit = 15'(`NBH_RST_PRG_CYC);
      NBH_BW_RST_ERASE: limit = RST_ERASE_LIMIT;
      default: limit = PROG_LIMIT;
    endcase
  end

  // Sequencer: one request at a time, every pin change on a cycle edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= NBH_ST_IDLE;
      cur <= '0;
      left <= 12'h000;
      aidx <= 3'h0;
      timer <= 15'h0000;
      req_ready <= 1'b0;
      op_done <= 1'b0;
      op_timeout <= 1'b0;
      op_refused <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      pins <= '{cmd_latch: 1'b0, addr_latch: 1'b0, chip_sel_n: 1'b1,
                write_strobe_n: 1'b1, output_strobe_n: 1'b1,
                protect_n: 1'b0};
    end
    else
    begin
      op_done <= 1'b0;
      op_timeout <= 1'b0;
      op_refused <= 1'b0;
      rd_valid <= 1'b0;
      req_ready <= 1'b0;
      case (state)
        NBH_ST_IDLE:
        begin
          // Chip select high between requests keeps the part in standby.
          pins.chip_sel_n <= 1'b1;
          io_oe <= 1'b0;
          req_ready <= 1'b1;
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            cur <= req;
            left <= req.count;
            aidx <= 3'h0;
            timer <= 15'h0000;
            case (req.op)
              NBH_OP_CMD:
              begin
                if (is_prog && same_row
                    && writes == `NBH_PARTIAL_WRITE_LIMIT)
                begin
                  op_refused <= 1'b1;
                  req_ready <= 1'b1;
                end
                else
                  state <= NBH_ST_SETUP;
              end
              NBH_OP_ADDR, NBH_OP_WRITE:
                state <= (req.count == 12'h000 && req.op == NBH_OP_WRITE)
                         ? NBH_ST_IDLE : NBH_ST_SETUP;
              NBH_OP_READ:
                state <= (req.count == 12'h000) ? NBH_ST_IDLE
                                                 : NBH_ST_RLOW;
              NBH_OP_WAIT:
              begin
                cur.count <= {limit[11:0]};
                timer <= limit;
                state <= NBH_ST_BUSY;
              end
              default:
              begin
                // Protect level change, then settle before any write.
                pins.protect_n <= req.value[0];
                timer <= 15'(`NBH_WW_CYC);
                state <= NBH_ST_GAP;
              end
            endcase
            if (req.op == NBH_OP_READ && req.count != 12'h000)
            begin
              pins.chip_sel_n <= 1'b0;
              pins.output_strobe_n <= 1'b0;
            end
            if (req.op == NBH_OP_WRITE && req.count == 12'h000)
              op_done <= 1'b1;
            if (req.op == NBH_OP_READ && req.count == 12'h000)
              op_done <= 1'b1;
          end
        end
        NBH_ST_SETUP:
        begin
          // Latches, select and data settle while the strobe is high.
          pins.chip_sel_n <= 1'b0;
          pins.cmd_latch <= (cur.op == NBH_OP_CMD);
          pins.addr_latch <= (cur.op == NBH_OP_ADDR);
          pins.output_strobe_n <= 1'b1;
          io_oe <= 1'b1;
          if (cur.op == NBH_OP_CMD)
          begin
            io_out <= cur.value;
            state <= NBH_ST_WLOW;
          end
          else if (cur.op == NBH_OP_ADDR)
          begin
            io_out <= 8'(cur.addr >> {aidx, 3'h0});
            state <= NBH_ST_WLOW;
          end
          else if (fifo_valid)
          begin
            io_out <= fifo_data;
            state <= NBH_ST_WLOW;
          end
        end
        NBH_ST_WLOW:
        begin
          // Only the strobe moves here; controls stay put while it is low.
          pins.write_strobe_n <= 1'b0;
          state <= NBH_ST_WHIGH;
        end
        NBH_ST_WHIGH:
        begin
          pins.write_strobe_n <= 1'b1;
          if (cur.op == NBH_OP_ADDR && aidx != `NBH_ADDR_CYCLES - 3'h1)
          begin
            aidx <= aidx + 3'h1;
            state <= NBH_ST_SETUP;
          end
          else if (cur.op == NBH_OP_WRITE && left != 12'h001)
          begin
            left <= left - 12'h001;
            state <= NBH_ST_SETUP;
          end
          else
          begin
            // Address to data gap after addresses, write to busy after a command, write to read after data.
            if (cur.op == NBH_OP_ADDR)
              timer <= 15'(`NBH_ADL_CYC);
            else if (cur.op == NBH_OP_CMD)
              timer <= 15'(`NBH_WB_CYC);
            else
              timer <= 15'(`NBH_WHR_CYC);
            state <= NBH_ST_GAP;
          end
        end
        NBH_ST_RLOW:
        begin
          // Output strobe was low for one full cycle; release it.
          pins.output_strobe_n <= 1'b1;
          state <= NBH_ST_RHOLD;
        end
        NBH_ST_RHOLD:
          state <= NBH_ST_RTAKE;
        NBH_ST_RTAKE:
        begin
          // The synchronised byte now holds what the pins showed.
          rd_data <= io_s2;
          rd_valid <= 1'b1;
          if (left != 12'h001)
          begin
            left <= left - 12'h001;
            pins.output_strobe_n <= 1'b0;
            state <= NBH_ST_RLOW;
          end
          else
          begin
            timer <= 15'(`NBH_RHW_CYC);
            state <= NBH_ST_GAP;
          end
        end
        NBH_ST_GAP:
        begin
          pins.cmd_latch <= 1'b0;
          pins.addr_latch <= 1'b0;
          if (timer <= 15'h0001)
          begin
            op_done <= 1'b1;
            state <= NBH_ST_IDLE;
          end
          else
            timer <= timer - 15'h0001;
        end
        NBH_ST_BUSY:
        begin
          // Bounded wait: a flash that never comes ready is reported.
          io_oe <= 1'b0;
          if (rb_s2)
          begin
            op_done <= 1'b1;
            state <= NBH_ST_IDLE;
          end
          else if (timer == 15'h0000)
          begin
            op_timeout <= 1'b1;
            op_done <= 1'b1;
            state <= NBH_ST_IDLE;
          end
          else
            timer <= timer - 15'h0001;
        end
        default:
          state <= NBH_ST_IDLE;
      endcase
    end
  end

  // Row of the latest address and per-page program budget.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pend_row <= 24'h000000;
      last_row <= 24'h000000;
      writes <= 3'h0;
    end
    else if (req_valid && req_ready && state == NBH_ST_IDLE)
    begin
      if (req.op == NBH_OP_ADDR)
        pend_row <= req.addr[`NBH_ROW_LSB +: 24];
      else if (req.op == NBH_OP_CMD && req.value == `NBH_CMD_ERASE_GO)
        writes <= 3'h0;
      else if (req.op == NBH_OP_CMD && is_prog)
      begin
        if (!same_row)
        begin
          last_row <= pend_row;
          writes <= 3'h1;
        end
        else if (writes != `NBH_PARTIAL_WRITE_LIMIT)
          writes <= writes + 3'h1;
      end
    end
  end

  // Cache read stays open until the last-page code or a reset.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cache_read_open <= 1'b0;
    else if (req_valid && req_ready && state == NBH_ST_IDLE
             && req.op == NBH_OP_CMD)
    begin
      if (req.value == `NBH_CMD_CACHE_READ)
        cache_read_open <= 1'b1;
      else if (req.value == `NBH_CMD_CACHE_LAST
               || req.value == `NBH_CMD_RESET)
        cache_read_open <= 1'b0;
    end
  end

endmodule

// file: verif/nbh_ctrl_props.sv
module nbh_ctrl_props
  import nbh_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic op_done,
  input wire logic op_timeout,
  input wire logic op_refused,
  input wire nbh_pins_t pins,
  input wire logic io_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] acnt;

  // Counts strobes inside one address burst, so a short burst is caught.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !pins.addr_latch)
      acnt <= 4'h0;
    else if ($rose(pins.write_strobe_n))
      acnt <= acnt + 4'h1;
  end

  // A read pulse must be followed by its byte within a few cycles.
  sequence s_read_pulse;
    $fell(pins.output_strobe_n);
  endsequence
  sequence s_byte_back;
    ##[1:4] rd_valid;
  endsequence

  chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
    pins.chip_sel_n && pins.write_strobe_n && pins.output_strobe_n &&
    !pins.protect_n && !io_oe && !op_done)
    else $error("pins not idle after reset");
  chk_ctrl_steady: assert property (!pins.write_strobe_n |=>
    $stable({pins.cmd_latch, pins.addr_latch, pins.chip_sel_n}))
    else $error("control moved while write strobe low");
  chk_addr_mode: assert property (pins.addr_latch &&
    !pins.write_strobe_n |-> !pins.cmd_latch && !pins.chip_sel_n &&
    pins.output_strobe_n)
    else $error("address cycle with wrong controls");
  chk_addr_count: assert property ($fell(pins.addr_latch) |->
    acnt == 4'h5)
    else $error("address burst not five strobes");
  chk_protect_settle: assert property ($changed(pins.protect_n) |->
    pins.write_strobe_n [*2])
    else $error("write strobe too soon after protect change");
  chk_read_mode: assert property (s_read_pulse |->
    !pins.cmd_latch && !pins.addr_latch && !pins.chip_sel_n && !io_oe)
    else $error("read pulse with wrong controls");
  chk_read_byte: assert property (s_read_pulse |-> s_byte_back)
    else $error("read byte not delivered");
  chk_timeout_pair: assert property (op_timeout |-> op_done)
    else $error("timeout without done");
  chk_taken_drop: assert property (req_valid && req_ready |=>
    !req_ready || op_refused)
    else $error("ready held after request taken");
  chk_done_ready: assert property (op_done |=> req_ready)
    else $error("not ready after done");
  chk_refuse_quiet: assert property (op_refused |->
    !op_done && pins.write_strobe_n)
    else $error("refused request still ran");
endmodule

bind nbh_ctrl nbh_ctrl_props u_nbh_ctrl_props (.sys_clk(sys_clk),
  .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
  .rd_valid(rd_valid), .op_done(op_done), .op_timeout(op_timeout),
  .op_refused(op_refused), .pins(pins), .io_oe(io_oe));

// file: verif/nbh_flash_model.sv
module nbh_flash_model
  import nbh_pkg::*;
(
  input wire logic sys_clk,
  input wire nbh_pins_t pins,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic [15:0] busy_len,
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_cmd;
  logic [39:0] addr;
  int n_addr = 0;
  int busy_left = 0;
  int rd_idx = 0;
  logic [7:0] got[$];
  logic [7:0] rd_byte;

  // Busy length is set by the bench, so waits can be short or overlong.
  assign ready_busy_n = (busy_left == 0);
  assign rd_byte = 8'ha5 ^ 8'(rd_idx);
  // A released bus shows the inverse byte, so a late sample cannot pass.
  assign io_in = (!pins.chip_sel_n && !pins.output_strobe_n) ? rd_byte :
    ~rd_byte;

  // Cycles decode on the write strobe rising edge of a selected chip.
  always @(posedge pins.write_strobe_n)
  begin
    if (pins.chip_sel_n === 1'b0 && pins.cmd_latch === 1'b1)
    begin
      last_cmd = io_out;
      n_addr = 0;
      rd_idx = 0;
      if (io_out inside {8'h30, 8'h31, 8'h3f, 8'hff} || (pins.protect_n &&
        io_out inside {8'h10, 8'h11, 8'h15, 8'hd0}))
        busy_left = busy_len;
    end
    else if (pins.chip_sel_n === 1'b0 && pins.addr_latch === 1'b1)
    begin
      if (n_addr < 5)
        addr[8*n_addr +: 8] = io_out;
      n_addr++;
    end
    else if (pins.chip_sel_n === 1'b0)
      got.push_back(io_out);
  end

  // Busy time runs down on the system clock.
  always @(posedge sys_clk)
    if (busy_left > 0)
      busy_left--;

  // Each read pulse steps to the next register byte.
  always @(posedge pins.output_strobe_n)
    if (pins.chip_sel_n === 1'b0)
      rd_idx++;
endmodule

// file: verif/tb_top.sv
module tb_top
  import nbh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  nbh_req_t req = '0;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [15:0] busy_len = 16'h0005;
  logic req_ready, wr_ready, rd_valid, op_done, op_timeout, op_refused;
  logic [7:0] rd_data, io_out, io_in;
  logic io_oe, ready_busy_n, cache_read_open;
  nbh_pins_t pins;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  logic [7:0] rd_q[$];
  logic [39:0] addr = '0;

  always #25 sys_clk = ~sys_clk;

  nbh_ctrl #(.PROG_LIMIT(15'h0032), .CACHE_PROG_LIMIT(15'h0032),
    .RST_ERASE_LIMIT(15'h0032)) u_nbh_ctrl (.sys_clk(sys_clk), .rst(rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done),
    .op_timeout(op_timeout), .op_refused(op_refused),
    .cache_read_open(cache_read_open), .pins(pins), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n));
  nbh_flash_model u_nbh_flash_model (.sys_clk(sys_clk), .pins(pins),
    .io_out(io_out), .io_oe(io_oe), .busy_len(busy_len), .io_in(io_in),
    .ready_busy_n(ready_busy_n));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp,
    input string what);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  // Offers one request, then collects bytes and flags until it ends.
  task automatic issue(input nbh_op_t o, input logic [7:0] v,
    input logic [11:0] n, input nbh_wait_t w, input logic [2:0] f);
    int k;
    logic [2:0] s;
    k = 0;
    s = 3'b000;
    req <= '{op: o, value: v, addr: addr, count: n, wclass: w};
    req_valid <= 1'b1;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    req_valid <= 1'b0;
    rd_q.delete();
    for (k = 0; k < 3000 && !s[2] && !s[0]; k++)
    begin
      @(posedge sys_clk);
      if (rd_valid === 1'b1)
        rd_q.push_back(rd_data);
      s = s | {op_done === 1'b1, op_timeout === 1'b1, op_refused === 1'b1};
    end
    cmp(40'(s), 40'(f), "done timeout refused");
    // The next request waits one cycle past the end of this one.
    @(posedge sys_clk);
  endtask

  // Offers random bytes for 40 cycles, more than the buffer takes before it refuses them.
  task automatic fill;
    int k;
    wr_valid <= 1'b1;
    wr_data <= 8'($urandom);
    for (k = 0; k < 40; k++)
    begin
      @(posedge sys_clk);
      if (wr_ready === 1'b1)
      begin
        exp_q.push_back(wr_data);
        wr_data <= 8'($urandom);
      end
    end
    wr_valid <= 1'b0;
  endtask

  // A hang is cut short well beyond the several hundred cycles expected.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end

  initial
  begin
    int i;
    i = $urandom(32'h4554);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmp(40'({pins.chip_sel_n, pins.output_strobe_n, pins.protect_n, io_oe}),
      40'hc, "reset pins");
    issue(NBH_OP_PROTECT, 8'h01, 12'h0, NBH_BW_ARRAY, 3'b100);
    cmp(40'(pins.protect_n), 40'h1, "protect level");
    addr = 40'({$urandom, $urandom});
    issue(NBH_OP_CMD, 8'h80, 12'h0, NBH_BW_ARRAY, 3'b100);
    issue(NBH_OP_ADDR, 8'h00, 12'h0, NBH_BW_ARRAY, 3'b100);
    cmp(u_nbh_flash_model.addr, addr, "address bytes");
    cmp(40'(u_nbh_flash_model.n_addr), 40'h5, "address count");
    u_nbh_flash_model.got.delete();
    fill;
    cmp(40'({wr_ready, exp_q.size() >= 32}), 40'h1, "buffer full");
    issue(NBH_OP_WRITE, 8'h00, 12'(exp_q.size()), NBH_BW_ARRAY, 3'b100);
    cmp(40'(u_nbh_flash_model.got.size()), 40'(exp_q.size()), "n bytes");
    foreach (exp_q[j])
      cmp(40'(u_nbh_flash_model.got[j]), 40'(exp_q[j]), "byte");
    for (i = 0; i < 5; i++)
    begin
      busy_len <= (i == 1) ? 16'h0050 : 16'($urandom_range(4, 12));
      issue(NBH_OP_CMD, 8'h10, 12'h0, NBH_BW_ARRAY,
        (i == 4) ? 3'b001 : 3'b100);
      if (i < 4)
        issue(NBH_OP_WAIT, 8'h00, 12'h0, NBH_BW_PROG,
          (i == 1) ? 3'b110 : 3'b100);
    end
    issue(NBH_OP_CMD, 8'hd0, 12'h0, NBH_BW_ARRAY, 3'b100);
    issue(NBH_OP_WAIT, 8'h00, 12'h0, NBH_BW_RST_ERASE, 3'b100);
    issue(NBH_OP_CMD, 8'h10, 12'h0, NBH_BW_ARRAY, 3'b100);
    issue(NBH_OP_WAIT, 8'h00, 12'h0, NBH_BW_PROG, 3'b100);
    for (i = 0; i < 9; i++)
    begin
      busy_len <= 16'($urandom_range(3, 12));
      issue(NBH_OP_CMD, 8'hff, 12'h0, NBH_BW_ARRAY, 3'b100);
      issue(NBH_OP_WAIT, 8'h00, 12'h0, nbh_wait_t'(i), 3'b100);
    end
    issue(NBH_OP_CMD, 8'h30, 12'h0, NBH_BW_ARRAY, 3'b100);
    issue(NBH_OP_WAIT, 8'h00, 12'h0, NBH_BW_ARRAY, 3'b100);
    issue(NBH_OP_READ, 8'h00, 12'h4, NBH_BW_ARRAY, 3'b100);
    cmp(40'(rd_q.size()), 40'h4, "read count");
    foreach (rd_q[j])
      cmp(40'(rd_q[j]), 40'(8'ha5 ^ 8'(j)), "read byte");
    issue(NBH_OP_READ, 8'h00, 12'h0, NBH_BW_ARRAY, 3'b100);
    cmp(40'(rd_q.size()), 40'h0, "empty read");
    issue(NBH_OP_CMD, 8'h31, 12'h0, NBH_BW_ARRAY, 3'b100);
    cmp(40'(cache_read_open), 40'h1, "cache open");
    issue(NBH_OP_WAIT, 8'h00, 12'h0, NBH_BW_CACHE_READ, 3'b100);
    issue(NBH_OP_CMD, 8'h3f, 12'h0, NBH_BW_ARRAY, 3'b100);
    cmp(40'(cache_read_open), 40'h0, "cache closed");
    wrap_up;
  end
endmodule
